/* File: bench/frag_sink.sv */
// fragment sink that stands downstream of the rasterizer and keeps every accepted fragment
// assumes raster_pkg types and a stream that must hold its word while the sink refuses it
`timescale 1ns/1ps
module frag_sink (
	input wire logic clk_in, // clock
	input wire logic stall_in, // refuse every other cycle
	input wire logic valid_in, // fragment offered
	input wire raster_pkg::frag_t frag_in, // fragment
	input wire raster_pkg::sprite_t sprite_in, // sprite coordinates
	output logic ready_out, // sink accepts
	output int hold_errs_out // count of words that moved while refused
);
	raster_pkg::frag_t got_f[$];
	raster_pkg::sprite_t got_s[$];
	raster_pkg::frag_t last_f;
	raster_pkg::sprite_t last_s;
	logic held;
	// start ready so nothing waits before the first stall
	initial begin
		ready_out = 1'b1;
		hold_errs_out = 0;
		held = 1'b0;
	end
	// toggling ready makes every fragment loaded while ready is high meet at least one refused edge
	always @(posedge clk_in) begin
		if (held && (valid_in !== 1'b1 || frag_in !== last_f || sprite_in !== last_s)) begin
			hold_errs_out <= hold_errs_out + 1;
		end
		if (valid_in === 1'b1 && ready_out === 1'b1) begin
			got_f.push_back(frag_in);
			got_s.push_back(sprite_in);
		end
		held <= valid_in === 1'b1 && ready_out !== 1'b1;
		last_f <= frag_in;
		last_s <= sprite_in;
		ready_out <= stall_in ? ~ready_out : 1'b1;
	end
endmodule

/* File: bench/testbench.sv */
// self-checking bench: register accesses, points and lines through the rasterizer
// assumes raster_pkg, raster_defines.svh and the frag_sink model downstream
`timescale 1ns/1ps
`include "raster_defines.svh"
module testbench;
	logic clk, rst_n, wr, rd, sbuf, pvalid, fready, stall, pready, fvalid;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	raster_pkg::prim_t prim;
	raster_pkg::frag_t frag;
	raster_pkg::sprite_t sprite;
	raster_pkg::frag_t ef[$];
	raster_pkg::sprite_t es[$];
	int errors, checks, herrs, chk_s;
	int pa[3][4] = '{'{0, 'h60, 'hf0, 'h1e0}, '{0, 'hf0, 'h1e0, 'h2d0}, '{4{'h3c0}}};
	point_line_rasterizer point_line_rasterizer_i (.CLOCK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .SAMPLE_BUF_IN(sbuf),
		.PRIM_VALID_IN(pvalid), .PRIM_IN(prim), .PRIM_READY_OUT(pready), .FRAG_VALID_OUT(fvalid),
		.FRAG_OUT(frag), .SPRITE_COORD_OUT(sprite), .FRAG_READY_IN(fready));
	frag_sink frag_sink_i (.clk_in(clk), .stall_in(stall), .valid_in(fvalid), .frag_in(frag),
		.sprite_in(sprite), .ready_out(fready), .hold_errs_out(herrs));
	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task check(input logic [68:0] seen, input logic [68:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe, so sample mid-cycle
	task rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(rdata, e);
	endtask
	task rej(input logic [7:0] a, input logic [31:0] d);
		wr_reg(a, d);
		rdc(a, 'h10);
		rdc(`REG_STATUS, 1);
		wr_reg(`REG_STATUS, 1);
		rdc(`REG_STATUS, 0);
	endtask
	function raster_pkg::vertex_t v(input int x, y, z, w, a, sz);
		return '{x[15:0], y[15:0], z[15:0], w[15:0], a[15:0], sz[15:0]};
	endfunction
	task ex(input int x, y, z, a, f, c, s, t);
		raster_pkg::frag_t e;
		raster_pkg::sprite_t q;
		e = '{x[11:0], y[11:0], z[15:0], a[15:0], f[8:0], c[3:0]};
		q = '{s[15:0], t[15:0]};
		ef.push_back(e);
		es.push_back(q);
	endtask
	task pe(input int x, y, s, t, c = 15, f = 'h100);
		ex(x, y, 'h123, 'h55, f, c, s, t);
	endtask
	// offer one primitive, wait until the block is idle and quiet, then compare all fragments
	task draw(input raster_pkg::prim_t p);
		int n;
		@(posedge clk);
		prim <= p;
		pvalid <= 1'b1;
		@(posedge clk);
		for (n = 0; n < 200 && pready !== 1'b1; n++) @(posedge clk);
		pvalid <= 1'b0;
		@(posedge clk);
		check(pready, 0);
		n = 0;
		for (int k = 0; k < 3000 && n < 4; k++) begin
			@(posedge clk);
			n = (pready === 1'b1 && fvalid !== 1'b1) ? n + 1 : 0;
		end
		check(frag_sink_i.got_f.size(), ef.size());
		foreach (ef[i]) begin
			check(frag_sink_i.got_f[i], ef[i]);
			if (chk_s) check(frag_sink_i.got_s[i], es[i]);
		end
		ef.delete();
		es.delete();
		frag_sink_i.got_f.delete();
		frag_sink_i.got_s.delete();
	endtask
	task pt(input int x, y, sz);
		raster_pkg::prim_t p;
		p = '{1'b0, raster_pkg::INTERP_PERSP, 1'b0, v(x, y, 'h123, 16, 'h55, sz), v(0, 0, 0, 16, 0, 0)};
		draw(p);
	endtask
	task ln(input int ax, ay, bx, by, zb, wb, ab, m);
		raster_pkg::prim_t p;
		p = '{1'b1, raster_pkg::interp_t'(m), 1'b1, v(ax, ay, 0, 16, 0, 0), v(bx, by, zb, wb, ab, 0)};
		draw(p);
	endtask
	// hang guard: the sequence needs a few hundred cycles
	initial begin
		#200000;
		errors++;
		results();
	end
	// main sequence
	initial begin
		{rst_n, wr, rd, sbuf, pvalid, addr, wdata, prim} = '0;
		stall = 1'b1;
		chk_s = 1;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rdc(`REG_CTRL, 0);
		rdc(`REG_PSIZE, 'h10);
		rdc(`REG_LWIDTH, 'h10);
		rdc(`REG_FADE, 'h10);
		rdc(`REG_STATUS, 0);
		rej(`REG_PSIZE, 0);
		rej(`REG_LWIDTH, 'hffff);
		rej(`REG_FADE, 'h8000);
		wr_reg(`REG_FADE, 0);
		rdc(`REG_FADE, 0);
		rdc(`REG_STATUS, 0);
		wr_reg(`REG_LWIDTH, 'h30);
		rdc(`REG_LWIDTH, 'h30);
		rdc(8'h14, 0);
		// single-sample points; centers on the square edge must not appear
		pe(5, 7, 'h80, 'h80);
		pt('h58, 'h78, 0);
		pt('h50, 'h78, 0);
		wr_reg(`REG_PSIZE, 'h20);
		for (int o = 0; o < 2; o++) begin
			wr_reg(`REG_CTRL, o * 2);
			for (int y = 6; y < 8; y++) for (int x = 4; x < 6; x++) pe(x, y, x == 4 ? 'h40 : 'hc0, ((y == 6) ^ o) ? 'hc0 : 'h40);
			pt('h50, 'h70, 0);
		end
		rdc(`REG_CTRL, 2);
		wr_reg(`REG_CTRL, 1);
		pe(5, 7, 'he0, 'h80);
		pt('h52, 'h78, 'h08);
		// multisample needs both the enable and a sample buffer
		wr_reg(`REG_PSIZE, 'h10);
		wr_reg(`REG_CTRL, 4);
		pt('h50, 'h78, 0);
		sbuf <= 1'b1;
		pe(4, 7, 0, 'h80, 'ha);
		pe(5, 7, 'h100, 'h80, 'h5);
		pt('h50, 'h78, 0);
		wr_reg(`REG_FADE, 'h20);
		wr_reg(`REG_CTRL, 'hc);
		chk_s = 0;
		for (int y = 6; y < 9; y++) for (int x = 4; x < 6; x++) pe(x, y, 0, 0, y == 6 ? 'hc : y == 7 ? 'hf : 'h3, 'h40);
		pt('h50, 'h78, 0);
		chk_s = 1;
		// lines: interpolation modes, joins, y-major and slope one
		wr_reg(`REG_CTRL, 0);
		for (int m = 0; m < 3; m++) begin
			for (int k = 0; k < 4; k++) ex(k + 1, 1, k * 'h100, pa[m][k], 'h100, 15, 0, 0);
			ln('h18, 'h18, 'h58, 'h18, 'h400, 'h30, 'h3c0, m);
		end
		for (int k = 0; k < 4; k++) ex(k + 5, 1, k * 'h100, k * 'h100, 'h100, 15, 0, 0);
		ln('h58, 'h18, 'h98, 'h18, 'h400, 16, 'h400, 1);
		// lengths of four pixels keep t exact on the Q12 grid
		for (int k = 0; k < 4; k++) ex(2, k + 1, k * 'h100, k * 'h100, 'h100, 15, 0, 0);
		ln('h28, 'h18, 'h28, 'h58, 'h400, 16, 'h400, 1);
		for (int k = 0; k < 4; k++) ex(5 - k, 5 - k, k * 'h100, k * 'h100, 'h100, 15, 0, 0);
		ln('h58, 'h58, 'h18, 'h18, 'h400, 16, 'h400, 1);
		check(herrs, 0);
		results();
	end
endmodule

/* File: logic/point_line_rasterizer.sv */
// point and one-pixel line rasterizer, one candidate pixel per clock
// assumes a primitive source with valid/ready and a fragment sink that may stall
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "raster_defines.svh"
// What this block does
// - shader size mode takes the vertex-written size, clamped to range
// - programmed point size resets to 1.0, nonpositive writes rejected
// - fade with multisampling: width at least threshold, fade squared ratio
// - negative fade threshold writes rejected, value kept
// - sprite origin bit, resets to upper-left
// - single-sample point: pixel centers strictly inside size square
// - point fragments carry vertex data; s from x offset over size
// - t uses y offset, sign by origin; other components fixed 0 and 1 (only s and t are output here)
// - unsupported widths replaced by nearest supported
// - point state: width, shader size bit, origin bit, threshold
// - multisample point: fragment per pixel with covered sample, mask bits
// - multisample point samples all take the point's data
// - line width resets to 1.0, nonpositive writes rejected
// - x-major when slope in [-1,1], y-major handled with axes swapped
// - diamond-exit selection, end diamond not emitted
// - endpoints treated as nudged down-left by epsilon
// - half-open segments, shared vertex drawn once
// - alternative algorithm stays within one unit and one fragment
// - one fragment per major column, no gaps or duplicates at joins
// - t is projection of center on segment, perspective interpolation
// - depth linear in t
// - no-perspective linear, flat takes provoking vertex
// - each fragment carries a one-bit-per-sample mask
// - multisample off: center rasterization, full coverage
module point_line_rasterizer (
	input wire logic CLOCK_IN, // 100 MHz
	input wire logic RST_N_IN, // synchronous reset, active low
	input wire logic [7:0] REG_ADDR_IN, // register byte address
	input wire logic [31:0] REG_WDATA_IN, // write data
	input wire logic REG_WR_IN, // write strobe
	input wire logic REG_RD_IN, // read strobe
	output logic [31:0] REG_RDATA_OUT, // read data, cycle after strobe
	input wire logic SAMPLE_BUF_IN, // sample buffer present
	input wire logic PRIM_VALID_IN, // primitive offered
	input wire raster_pkg::prim_t PRIM_IN, // primitive
	output logic PRIM_READY_OUT, // primitive taken
	output logic FRAG_VALID_OUT, // fragment offered
	output raster_pkg::frag_t FRAG_OUT, // fragment
	output raster_pkg::sprite_t SPRITE_COORD_OUT, // sprite s,t of fragment
	input wire logic FRAG_READY_IN // sink accepts
);
	logic [3:0] ctrl;
	logic [15:0] point_size;
	logic [15:0] line_width;
	logic [15:0] fade_thr;
	logic invalid_value;
	raster_pkg::state_t state;
	raster_pkg::prim_t p;
	logic ms_on;
	logic [15:0] width;
	logic [8:0] fade;
	logic signed [11:0] cx, cy, x_lo, x_hi, y_hi;
	logic xmaj, dir_up;
	logic signed [16:0] ma, mb, na, dm, dn;
	logic hit, in_range, last, slot_free, take;
	logic [`SAMPLES-1:0] cov_mask;
	logic signed [15:0] cxc, cyc, s_val, t_val;
	logic signed [11:0] minor_pix;
	logic [15:0] z_val;
	logic signed [15:0] attr_val;
	logic signed [19:0] t_line;
	logic [15:0] derived;
	logic wsigned_bad;

	// clamp to the supported range; the 1/16 grid is itself the gradation
	function automatic logic [15:0] clamp_size(input logic [15:0] v);
		if (v < `PSIZE_MIN) begin
			return `PSIZE_MIN;
		end else if (v > `PSIZE_MAX) begin
			return `PSIZE_MAX;
		end
		return v;
	endfunction

	// true when a coordinate lies strictly inside the half-width band
	function automatic logic in_band(input logic signed [15:0] c, input logic signed [15:0] ctr,
			input logic [15:0] w);
		logic signed [17:0] d;
		d = 18'(c) - 18'(ctr);
		if (d < 0) begin
			d = -d;
		end
		return (d <<< 1) < $signed({2'b00, w});
	endfunction

	// pixel containing a fixed-point coordinate
	function automatic logic signed [11:0] pix_of(input logic signed [16:0] v);
		return 12'(v >>> 4);
	endfunction

	// register writes; a rejected value leaves the stored one alone
	assign wsigned_bad = $signed(REG_WDATA_IN[15:0]) <= 0;
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			ctrl <= `RST_CTRL;
			point_size <= `RST_SIZE;
			line_width <= `RST_SIZE;
			fade_thr <= `RST_FADE;
		end else if (REG_WR_IN) begin
			if (REG_ADDR_IN == `REG_CTRL) begin
				ctrl <= REG_WDATA_IN[3:0];
			end else if (REG_ADDR_IN == `REG_PSIZE && !wsigned_bad) begin
				point_size <= REG_WDATA_IN[15:0];
			end else if (REG_ADDR_IN == `REG_LWIDTH && !wsigned_bad) begin
				line_width <= REG_WDATA_IN[15:0];
			end else if (REG_ADDR_IN == `REG_FADE && !REG_WDATA_IN[15]) begin
				fade_thr <= REG_WDATA_IN[15:0];
			end
		end
	end

	// sticky error flag, write one to clear; a new error in the same cycle wins
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			invalid_value <= 1'b0;
		end else if (REG_WR_IN && (((REG_ADDR_IN == `REG_PSIZE || REG_ADDR_IN == `REG_LWIDTH) && wsigned_bad)
				|| (REG_ADDR_IN == `REG_FADE && REG_WDATA_IN[15]))) begin
			invalid_value <= 1'b1;
		end else if (REG_WR_IN && REG_ADDR_IN == `REG_STATUS && REG_WDATA_IN[`ST_INVALID]) begin
			invalid_value <= 1'b0;
		end
	end

	// read data, unmapped addresses read zero
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			REG_RDATA_OUT <= 32'h0;
		end else if (!REG_RD_IN) begin
			REG_RDATA_OUT <= 32'h0;
		end else if (REG_ADDR_IN == `REG_CTRL) begin
			REG_RDATA_OUT <= {28'h0, ctrl};
		end else if (REG_ADDR_IN == `REG_PSIZE) begin
			REG_RDATA_OUT <= {16'h0, point_size};
		end else if (REG_ADDR_IN == `REG_LWIDTH) begin
			REG_RDATA_OUT <= {16'h0, line_width};
		end else if (REG_ADDR_IN == `REG_FADE) begin
			REG_RDATA_OUT <= {16'h0, fade_thr};
		end else if (REG_ADDR_IN == `REG_STATUS) begin
			REG_RDATA_OUT <= {30'h0, state != raster_pkg::ST_IDLE, invalid_value};
		end else begin
			REG_RDATA_OUT <= 32'h0;
		end
	end

	// shader-written or programmed size, then clamped
	assign derived = clamp_size(ctrl[`CTRL_SHADER_SIZE] ? p.a.shader_written_size : point_size);

	assign PRIM_READY_OUT = state == raster_pkg::ST_IDLE;
	assign slot_free = !FRAG_VALID_OUT || FRAG_READY_IN;

	// sequencing: setup latches width and scan bounds, scan walks candidates
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			state <= raster_pkg::ST_IDLE;
			p <= '0;
			ms_on <= 1'b0;
		end else begin
			case (state)
				raster_pkg::ST_IDLE: begin
					if (PRIM_VALID_IN) begin
						p <= PRIM_IN;
						// multisample needs enable and a sample buffer
						ms_on <= ctrl[`CTRL_MS_EN] && SAMPLE_BUF_IN;
						state <= raster_pkg::ST_SETUP;
					end
				end
				raster_pkg::ST_SETUP: begin
					state <= raster_pkg::ST_SCAN;
				end
				raster_pkg::ST_SCAN: begin
					if (last && (!hit || take)) begin
						state <= raster_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= raster_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// setup math; line width stays one pixel, wide lines are not drawn here
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			width <= `RST_SIZE;
			fade <= `FADE_ONE;
			xmaj <= 1'b1;
			dir_up <= 1'b1;
			{ma, mb, na, dm, dn} <= '0;
			{x_lo, x_hi, y_hi} <= '0;
		end else if (state == raster_pkg::ST_SETUP) begin
			width <= derived;
			fade <= `FADE_ONE;
			// widen to threshold and fade by squared ratio
			if (ms_on && ctrl[`CTRL_FADE_EN] && derived < fade_thr) begin
				width <= fade_thr;
				fade <= 9'((({16'h0, derived} << 8) / {16'h0, fade_thr}) ** 2 >> 8);
			end
			// pick the major axis from endpoint deltas
			if ((p.b.y > p.a.y ? p.b.y - p.a.y : p.a.y - p.b.y) <= (p.b.x > p.a.x ? p.b.x - p.a.x : p.a.x - p.b.x)) begin
				xmaj <= 1'b1;
				ma <= 17'(p.a.x);
				mb <= 17'(p.b.x);
				na <= 17'(p.a.y);
				dm <= 17'(p.b.x) - 17'(p.a.x);
				dn <= 17'(p.b.y) - 17'(p.a.y);
				dir_up <= p.b.x >= p.a.x;
			end else begin
				xmaj <= 1'b0;
				ma <= 17'(p.a.y);
				mb <= 17'(p.b.y);
				na <= 17'(p.a.x);
				dm <= 17'(p.b.y) - 17'(p.a.y);
				dn <= 17'(p.b.x) - 17'(p.a.x);
				dir_up <= p.b.y >= p.a.y;
			end
			x_lo <= pix_of(17'(p.a.x) - 17'(derived > fade_thr ? derived : fade_thr));
			x_hi <= pix_of(17'(p.a.x) + 17'(derived > fade_thr ? derived : fade_thr));
			y_hi <= pix_of(17'(p.a.y) + 17'(derived > fade_thr ? derived : fade_thr));
		end
	end

	// scan position: point walks a box row by row, line walks the major axis
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			cx <= '0;
			cy <= '0;
		end else if (state == raster_pkg::ST_SETUP) begin
			cx <= p.is_line ? 12'sh0 : pix_of(17'(p.a.x) - 17'(derived > fade_thr ? derived : fade_thr));
			cy <= p.is_line ? 12'sh0 : pix_of(17'(p.a.y) - 17'(derived > fade_thr ? derived : fade_thr));
			// nudged start: first center at or past start going up, at or below it going down
			if (p.is_line) begin
				cx <= pix_of(((p.b.y > p.a.y ? p.b.y - p.a.y : p.a.y - p.b.y)
					<= (p.b.x > p.a.x ? p.b.x - p.a.x : p.a.x - p.b.x))
					? ((p.b.x >= p.a.x) ? 17'(p.a.x) + 17'sh7 : 17'(p.a.x) - 17'sh8)
					: ((p.b.y >= p.a.y) ? 17'(p.a.y) + 17'sh7 : 17'(p.a.y) - 17'sh8));
			end
		end else if (state == raster_pkg::ST_SCAN && (!hit || take)) begin
			if (p.is_line) begin
				cx <= dir_up ? cx + 12'sh1 : cx - 12'sh1;
			end else if (cx >= x_hi) begin
				cx <= x_lo;
				cy <= cy + 12'sh1;
			end else begin
				cx <= cx + 12'sh1;
			end
		end
	end

	// candidate evaluation
	always_comb begin
		logic signed [16:0] c;
		logic signed [16:0] n;
		logic signed [33:0] dot;
		logic signed [33:0] len2;
		c = '0;
		n = '0;
		dot = '0;
		len2 = '0;
		cov_mask = '0;
		t_line = '0;
		minor_pix = '0;
		in_range = 1'b0;
		cxc = 16'((cx <<< 4)) + `CENTER_OFS;
		cyc = 16'((cy <<< 4)) + `CENTER_OFS;
		if (p.is_line) begin
			c = 17'(cx <<< 4) + 17'(`CENTER_OFS);
			// stop before the end center, so shared vertices appear once
			in_range = dir_up ? (c < mb) : (c > mb);
			// one minor pixel per major step keeps columns single and joins gapless
			// per-column row from the exact line stays within one unit
			n = (dm != 0) ? na + 17'((34'(dn) * 34'(c - ma)) / 34'(dm)) : na;
			minor_pix = pix_of(n);
			cxc = xmaj ? 16'(c) : 16'((minor_pix <<< 4)) + `CENTER_OFS;
			cyc = xmaj ? 16'((minor_pix <<< 4)) + `CENTER_OFS : 16'(c);
			// projection of the center onto the segment
			dot = 34'(cxc - p.a.x) * 34'(p.b.x - p.a.x) + 34'(cyc - p.a.y) * 34'(p.b.y - p.a.y);
			len2 = 34'(p.b.x - p.a.x) * 34'(p.b.x - p.a.x) + 34'(p.b.y - p.a.y) * 34'(p.b.y - p.a.y);
			t_line = (len2 != 0) ? 20'((dot <<< `T_SHIFT) / len2) : 20'sh0;
			if (t_line < 0) begin
				t_line = '0;
			end else if (t_line > `T_ONE) begin
				t_line = `T_ONE;
			end
			// line multisampling is not drawn; mask stays full
			cov_mask = {`SAMPLES{in_range}};
		end else if (ms_on) begin
			// test each sample against the width square
			// sample offsets in sixteenths are exact in this format
			for (int i = 0; i < `SAMPLES; i++) begin
				// offset nibble is masked before the add, else the pixel base is lost
				cov_mask[i] = in_band(16'(cx <<< 4) + (16'(`SAMPLE_POS >> (8 * i + 4)) & 16'hf), p.a.x, width)
					&& in_band(16'(cy <<< 4) + (16'(`SAMPLE_POS >> (8 * i)) & 16'hf), p.a.y, width);
			end
		end else begin
			cov_mask = {`SAMPLES{in_band(cxc, p.a.x, width) && in_band(cyc, p.a.y, width)}};
		end
	end

	assign hit = state == raster_pkg::ST_SCAN && cov_mask != '0;
	assign last = p.is_line ? !in_range || !(dir_up ? (17'(cx <<< 4) + 17'sh18 < mb) : (17'(cx <<< 4) - 17'sh8 > mb))
		: (cx >= x_hi && cy >= y_hi);
	assign take = hit && slot_free;

	// line data interpolation
	always_comb begin
		logic signed [47:0] num;
		logic signed [47:0] den;
		logic signed [19:0] omt;
		omt = `T_ONE - t_line;
		z_val = 16'((48'(omt) * 48'({1'b0, p.a.z}) + 48'(t_line) * 48'({1'b0, p.b.z})) >>> `T_SHIFT);
		num = 48'(omt) * 48'(p.a.attr) * 48'({1'b0, p.b.w}) + 48'(t_line) * 48'(p.b.attr) * 48'({1'b0, p.a.w});
		den = 48'(omt) * 48'({1'b0, p.b.w}) + 48'(t_line) * 48'({1'b0, p.a.w});
		case (p.mode)
			raster_pkg::INTERP_LINEAR: begin
				attr_val = 16'((48'(omt) * 48'(p.a.attr) + 48'(t_line) * 48'(p.b.attr)) >>> `T_SHIFT);
			end
			raster_pkg::INTERP_FLAT: begin
				attr_val = p.provoke_b ? p.b.attr : p.a.attr;
			end
			default: begin
				// perspective weight by the opposite endpoint w
				attr_val = (den != 0) ? 16'(num / den) : p.a.attr;
			end
		endcase
	end

	// s rises left to right across the point
	// t sign follows the origin bit; the sprite output carries s and t only
	assign s_val = `SPRITE_HALF + 16'((32'(cxc - p.a.x) <<< 8) / $signed({16'h0, width}));
	assign t_val = ctrl[`CTRL_ORIGIN_BOTTOM]
		? `SPRITE_HALF + 16'((32'(cyc - p.a.y) <<< 8) / $signed({16'h0, width}))
		: `SPRITE_HALF - 16'((32'(cyc - p.a.y) <<< 8) / $signed({16'h0, width}));

	// output stage; an offered fragment holds while the sink stalls, an empty slot still loads
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			FRAG_VALID_OUT <= 1'b0;
			FRAG_OUT <= '0;
			SPRITE_COORD_OUT <= '0;
		end else if (slot_free) begin
			// load only into a free slot
			FRAG_VALID_OUT <= hit;
			if (hit) begin
				FRAG_OUT.x <= p.is_line && !xmaj ? minor_pix : cx;
				FRAG_OUT.y <= p.is_line ? (xmaj ? minor_pix : cx) : cy;
				FRAG_OUT.z <= p.is_line ? z_val : p.a.z;
				FRAG_OUT.attr <= p.is_line ? attr_val : p.a.attr;
				FRAG_OUT.fade <= p.is_line ? `FADE_ONE : fade;
				// mask with one bit per sample
				FRAG_OUT.mask <= cov_mask;
				SPRITE_COORD_OUT <= p.is_line ? '0 : {s_val, t_val};
			end
		end
	end

	a_psize_reject: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		REG_WR_IN && REG_ADDR_IN == `REG_PSIZE && wsigned_bad |=> $stable(point_size) && invalid_value)
		else $error("bad point size stored");
	a_thr_reject: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		REG_WR_IN && REG_ADDR_IN == `REG_FADE && REG_WDATA_IN[15] |=> $stable(fade_thr) && invalid_value)
		else $error("negative threshold stored");
	a_width_reject: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		REG_WR_IN && REG_ADDR_IN == `REG_LWIDTH && wsigned_bad |=> $stable(line_width) ##1 $stable(line_width)
		|| $past(REG_WR_IN)) else $error("bad line width stored");
	a_origin_reset: assert property (@(posedge CLOCK_IN)
		!RST_N_IN |=> !ctrl[`CTRL_ORIGIN_BOTTOM] && point_size == `RST_SIZE) else $error("reset state wrong");
	a_out_hold: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		FRAG_VALID_OUT && !FRAG_READY_IN |=> FRAG_VALID_OUT && $stable(FRAG_OUT) && $stable(SPRITE_COORD_OUT))
		else $error("fragment changed under stall");
	a_cover_full: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		FRAG_VALID_OUT && !ms_on |-> FRAG_OUT.mask == {`SAMPLES{1'b1}}) else $error("mask not full");
	a_point_data: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		FRAG_VALID_OUT && !p.is_line |-> FRAG_OUT.attr == p.a.attr && FRAG_OUT.z == p.a.z)
		else $error("point data altered");
	a_width_range: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		state == raster_pkg::ST_SCAN && !ms_on |-> width >= `PSIZE_MIN && width <= `PSIZE_MAX)
		else $error("width out of range");
	a_fade_one: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		FRAG_VALID_OUT && !p.is_line && width == derived |-> FRAG_OUT.fade == `FADE_ONE)
		else $error("fade without narrowing");
	a_line_end: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		state == raster_pkg::ST_SCAN && p.is_line && !in_range |-> !hit) else $error("end fragment made");
	c_point: cover property (@(posedge CLOCK_IN) FRAG_VALID_OUT && FRAG_READY_IN && !p.is_line);
	c_line: cover property (@(posedge CLOCK_IN) FRAG_VALID_OUT && FRAG_READY_IN && p.is_line);
	c_stall: cover property (@(posedge CLOCK_IN) FRAG_VALID_OUT && !FRAG_READY_IN ##1 FRAG_READY_IN);
	c_reject: cover property (@(posedge CLOCK_IN) REG_WR_IN && REG_ADDR_IN == `REG_PSIZE && wsigned_bad);
endmodule

/* File: logic/raster_defines.svh */
// constants for the point and line rasterizer: register map, fields, resets, fixed-point scales
// assumes coordinates and sizes in fixed point with four fractional bits (1.0 == 16)
`ifndef RASTER_DEFINES_SVH
`define RASTER_DEFINES_SVH
`define REG_CTRL 8'h00
`define REG_PSIZE 8'h04
`define REG_LWIDTH 8'h08
`define REG_FADE 8'h0c
`define REG_STATUS 8'h10
`define CTRL_SHADER_SIZE 0
`define CTRL_ORIGIN_BOTTOM 1
`define CTRL_MS_EN 2
`define CTRL_FADE_EN 3
`define ST_INVALID 0
`define ST_BUSY 1
`define RST_CTRL 4'h0
`define RST_SIZE 16'h0010
`define RST_FADE 16'h0010
`define PSIZE_MIN 16'h0010
`define PSIZE_MAX 16'h0400
`define FRAC_ONE 16'sh0010
`define CENTER_OFS 16'sh0008
`define SPRITE_ONE 16'sh0100
`define SPRITE_HALF 16'sh0080
`define FADE_ONE 9'h100
`define T_ONE 20'sh01000
`define T_SHIFT 12
`define SAMPLES 4
// sample offsets inside the pixel, sixteenths, packed x3y3x2y2x1y1x0y0
`define SAMPLE_POS 32'hae2a_e662
`endif

/* File: logic/raster_pkg.sv */
// types shared by the rasterizer and its bench
// assumes raster_defines.svh for widths of the sample mask
`include "raster_defines.svh"
package raster_pkg;
	typedef enum logic [1:0] {
		INTERP_PERSP = 2'h0,
		INTERP_LINEAR = 2'h1,
		INTERP_FLAT = 2'h2
	} interp_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_SCAN = 2'b11
	} state_t;
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic [15:0] z;
		logic [15:0] w;
		logic signed [15:0] attr;
		logic [15:0] shader_written_size;
	} vertex_t;
	typedef struct packed {
		logic is_line;
		interp_t mode;
		logic provoke_b;
		vertex_t a;
		vertex_t b;
	} prim_t;
	typedef struct packed {
		logic signed [11:0] x;
		logic signed [11:0] y;
		logic [15:0] z;
		logic signed [15:0] attr;
		logic [8:0] fade;
		logic [`SAMPLES-1:0] mask;
	} frag_t;
	typedef struct packed {
		logic signed [15:0] s;
		logic signed [15:0] t;
	} sprite_t;
endpackage
